// file: verilog/psv_pkg.sv
// Behaviour
// - Four external interrupt pins raise requests on edges chosen by the edge register.
// - Each pin's detector selects rising only, falling only, or both edges.
// - A pin acts as interrupt only while its port select bit is 1.
// - Edges latch into request flags each cycle; acceptance looks one cycle later.
// - At least twelve cycles pass from request activation to service entry.
// - Writing 0Fh into the stop/sleep control register enters sleep.
// - Stop is entered only by the stop instruction after 5Ah was written.
// - In sleep the oscillator and peripheral clock run while the CPU halts; the watchdog stops.
// - Sleep ends on reset or any enabled interrupt.
// - Reset reinitialises control registers; interrupt wake keeps them except the stop/sleep control register, which clears.
// - Wake with master flag 1 vectors normally; with 0 resumes without vectoring.
// - On wake the interval timer counts 00 to FF; overflow restarts operation.
// - In stop main oscillator, system and peripheral clocks halt; RC watchdog runs.
// - Stop holds RAM, registers, latches and port drive values.
// - While stopped the program counter holds the next instruction address.
// - Stop halts interval timer, keeps prescaler; watchdog and event counters may run.
// - Both modes stop buzzer and converter; serial units use external clock only.
// - Stop ends on reset, event counters, serial units, RC watchdog or external interrupt.
// - Acceptance clears master flag and source flag, then CPU vectors.
package psv_pkg;

  localparam int          NUM_EXT       = 4;
  localparam int          WB_AW         = 10;
  localparam int          WB_DW         = 32;
  localparam int          STOP_SRC_N    = 5;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_EDGE_SEL  = 8'hee;
  localparam logic [7:0]  IDX_PORT_SEL  = 8'hf0;
  localparam logic [7:0]  IDX_SSC       = 8'hf1;
  localparam logic [7:0]  IDX_IRQ_EN    = 8'hf2;
  localparam logic [7:0]  IDX_IRQ_FLAG  = 8'hf3;
  localparam logic [7:0]  IDX_PRESC     = 8'hf4;
  localparam logic [7:0]  IDX_STATUS    = 8'hf5;

  localparam logic [7:0]  EDGE_SEL_RST  = 8'h00;
  localparam logic [3:0]  PORT_SEL_RST  = 4'h0;
  localparam logic [7:0]  SSC_RST       = 8'h00;
  localparam logic [3:0]  IRQ_EN_RST    = 4'h0;
  localparam logic [2:0]  PRESC_RST     = 3'h7;

  localparam logic [7:0]  SSC_SLEEP     = 8'h0f;
  localparam logic [7:0]  SSC_STOP      = 8'h5a;

  // Two bits per pin in the edge register
  localparam logic [1:0]  EDGE_FALL     = 2'h1;
  localparam logic [1:0]  EDGE_RISE     = 2'h2;
  localparam logic [1:0]  EDGE_BOTH     = 2'h3;

  localparam logic [7:0]  BIT_START     = 8'h00;
  localparam logic [7:0]  BIT_END       = 8'hff;
  localparam logic [3:0]  LAT_CYC       = 4'hc;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_STOP, ST_STAB} psv_state_e;

  typedef struct packed {
    logic cpu_halt;
    logic osc_run;
    logic sys_clk_run;
    logic periph_clk_run;
    logic bit_run;
    logic tmr_run;
    logic presc_run;
    logic wdt_run;
    logic buz_adc_run;
    logic serial_ext_only;
  } psv_gate_s;

endpackage : psv_pkg

// file: verilog/psv_ctrl.sv
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
module psv_ctrl (
  input  wire logic                            clk_sys,
  input  wire logic                            nrst,
  input  wire logic                            clk_en,
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [psv_pkg::WB_AW-1:0]       wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [psv_pkg::WB_DW-1:0]       wb_dat_i,
  output      logic [psv_pkg::WB_DW-1:0]       wb_dat_o,
  output      logic                            wb_ack_o,
  input  wire logic [psv_pkg::NUM_EXT-1:0]     ext_irq_pin,
  input  wire logic                            stop_exec,
  input  wire logic                            i_flag,
  input  wire logic                            periph_irq,
  input  wire logic [psv_pkg::STOP_SRC_N-1:0]  stop_wake_src,
  input  wire logic                            rc_watchdog_mode,
  input  wire logic                            evt_count_mode,
  output      psv_pkg::psv_gate_s              gate_reg,
  output      logic                            cpu_resume_reg,
  output      logic [psv_pkg::NUM_EXT-1:0]     int_accept_reg,
  output      logic                            i_flag_clr_reg
);
  import psv_pkg::*;

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  logic [7:0]         edge_sel_reg;
  logic [3:0]         port_sel_reg;
  logic [7:0]         ssc_reg;
  logic [3:0]         irq_en_reg;
  logic [3:0]         flag_reg;
  logic [2:0]         presc_sel_reg;
  psv_state_e         state_reg;
  psv_state_e         state_next;

  wire                bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land on the edge that sees ack, the one edge where the master samples it
  wire                bus_wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire  [7:0]         bus_idx   = wb_adr_i[9:2];
  wire  [7:0]         wdat      = wb_dat_i[7:0];
  wire                wr_edge   = bus_wr & (bus_idx == IDX_EDGE_SEL);
  wire                wr_psel   = bus_wr & (bus_idx == IDX_PORT_SEL);
  wire                wr_ssc    = bus_wr & (bus_idx == IDX_SSC);
  wire                wr_en     = bus_wr & (bus_idx == IDX_IRQ_EN);
  wire                wr_flag   = bus_wr & (bus_idx == IDX_IRQ_FLAG);
  wire                wr_presc  = bus_wr & (bus_idx == IDX_PRESC);
  wire  [3:0]         status    = {state_reg == ST_STAB, state_reg == ST_STOP,
                                   state_reg == ST_SLEEP, state_reg == ST_RUN};
  logic [7:0]         rd_byte;

  always_comb begin
    case (bus_idx)
      IDX_EDGE_SEL: rd_byte = edge_sel_reg;
      IDX_PORT_SEL: rd_byte = {4'h0, port_sel_reg};
      IDX_SSC:      rd_byte = ssc_reg;
      IDX_IRQ_EN:   rd_byte = {4'h0, irq_en_reg};
      IDX_IRQ_FLAG: rd_byte = {4'h0, flag_reg};
      IDX_PRESC:    rd_byte = {5'h00, presc_sel_reg};
      IDX_STATUS:   rd_byte = {4'h0, status};
      default:      rd_byte = 8'h00;
    endcase
  end

  // Unmapped indices still ack, reading zero, so the master never hangs
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  wire                leave_mode = (state_reg == ST_STAB) && (state_next == ST_RUN);

  // Reset reloads every control register; a wake keeps all but ssc_reg, which returns to SSC_RST
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      edge_sel_reg  <= EDGE_SEL_RST;
      port_sel_reg  <= PORT_SEL_RST;
      ssc_reg       <= SSC_RST;
      irq_en_reg    <= IRQ_EN_RST;
      presc_sel_reg <= PRESC_RST;
    end else if (clk_en) begin
      if (wr_edge) edge_sel_reg <= wdat;
      if (wr_psel) port_sel_reg <= wdat[3:0];
      if (wr_en) irq_en_reg <= wdat[3:0];
      if (wr_presc) presc_sel_reg <= wdat[2:0];
      // Code is consumed on wake so the mode is not re-entered at once
      if (wr_ssc) begin
        ssc_reg <= wdat;
      end else if (leave_mode) begin
        ssc_reg <= SSC_RST;
      end
    end
  end

  // ----------------------------------------------------------------
  // External pin synchronisers and edge detectors
  // ----------------------------------------------------------------
  logic [3:0]         sync1_reg;
  logic [3:0]         sync2_reg;
  logic [3:0]         prev_reg;
  logic [3:0]         set_vec;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg  <= 4'h0;
    end else if (clk_en) begin
      sync1_reg <= ext_irq_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Detection runs on the system clock, so a pin edge during stop is
  // seen only because this model keeps the edge logic clocked
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++) begin : g_edge
      wire [1:0] mode = edge_sel_reg[2*gi+1:2*gi];
      wire       rise = sync2_reg[gi] & ~prev_reg[gi];
      wire       fall = ~sync2_reg[gi] & prev_reg[gi];
      wire       hit  = ((mode == EDGE_RISE) & rise) |
                        ((mode == EDGE_FALL) & fall) |
                        ((mode == EDGE_BOTH) & (rise | fall));
      assign set_vec[gi] = hit & port_sel_reg[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Request flags and acceptance
  // ----------------------------------------------------------------
  logic [3:0]         pend_q_reg;
  logic [3:0]         lat_cnt_reg;
  wire  [3:0]         pend      = flag_reg & irq_en_reg;
  wire                acc_ok    = (state_reg == ST_RUN) & i_flag & (|pend_q_reg);
  wire                acc_fire  = acc_ok & (lat_cnt_reg == LAT_CYC - 4'h1);
  wire  [3:0]         acc_win   = pend_q_reg & (~pend_q_reg + 4'h1);
  wire  [3:0]         clr_vec   = (wr_flag ? wdat[3:0] : 4'h0) | (acc_fire ? acc_win : 4'h0);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flag_reg       <= 4'h0;
      pend_q_reg     <= 4'h0;
      lat_cnt_reg    <= 4'h0;
      int_accept_reg <= 4'h0;
      i_flag_clr_reg <= 1'b0;
    end else if (clk_en) begin
      // A new edge beats a clear in the same cycle
      flag_reg       <= (flag_reg & ~clr_vec) | set_vec;
      pend_q_reg     <= pend & ~clr_vec;
      lat_cnt_reg    <= (acc_ok && !acc_fire) ? lat_cnt_reg + 4'h1 : 4'h0;
      int_accept_reg <= acc_fire ? acc_win : 4'h0;
      i_flag_clr_reg <= acc_fire;
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencer and stabilisation count
  // ----------------------------------------------------------------
  logic [7:0]         presc_cnt_reg;
  logic [7:0]         bit_cnt_reg;
  wire  [7:0]         presc_mask = ~(8'hff << presc_sel_reg);
  wire                tick       = (presc_cnt_reg & presc_mask) == presc_mask;
  wire                irq_wake   = (|pend) | periph_irq;
  wire                stop_wake  = (|pend) | (|stop_wake_src);
  wire                bit_ovf    = tick & (bit_cnt_reg == BIT_END);
  psv_gate_s          gate_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (ssc_reg == SSC_SLEEP) begin
          state_next = ST_SLEEP;
        end else if ((ssc_reg == SSC_STOP) && stop_exec) begin
          state_next = ST_STOP;
        end
      end
      ST_SLEEP: begin
        if (irq_wake) state_next = ST_STAB;
      end
      ST_STOP: begin
        if (stop_wake) state_next = ST_STAB;
      end
      ST_STAB: begin
        if (bit_ovf) state_next = ST_RUN;
      end
      default: state_next = ST_RUN;
    endcase
  end

  always_comb begin
    gate_next                 = '0;
    gate_next.osc_run         = 1'b1;
    gate_next.sys_clk_run     = 1'b1;
    gate_next.periph_clk_run  = 1'b1;
    gate_next.bit_run         = 1'b1;
    gate_next.tmr_run         = 1'b1;
    gate_next.presc_run       = 1'b1;
    gate_next.wdt_run         = 1'b1;
    gate_next.buz_adc_run     = 1'b1;
    case (state_next)
      ST_RUN: begin
        gate_next.cpu_halt    = 1'b0;
      end
      ST_SLEEP: begin
        gate_next.cpu_halt        = 1'b1;
        gate_next.wdt_run         = 1'b0;
        gate_next.buz_adc_run     = 1'b0;
        gate_next.serial_ext_only = 1'b1;
      end
      ST_STOP: begin
        // CPU frozen here keeps the program counter at the next instruction
        gate_next.cpu_halt        = 1'b1;
        gate_next.osc_run         = 1'b0;
        gate_next.sys_clk_run     = 1'b0;
        gate_next.periph_clk_run  = 1'b0;
        gate_next.bit_run         = 1'b0;
        gate_next.presc_run       = 1'b0;
        gate_next.wdt_run         = rc_watchdog_mode;
        gate_next.tmr_run         = evt_count_mode;
        gate_next.buz_adc_run     = 1'b0;
        gate_next.serial_ext_only = 1'b1;
      end
      ST_STAB: begin
        gate_next.cpu_halt        = 1'b1;
        gate_next.buz_adc_run     = 1'b0;
        gate_next.serial_ext_only = 1'b1;
      end
      default: begin
        gate_next.cpu_halt    = 1'b0;
      end
    endcase
  end

  // Prescaler keeps its value through stop; the timer restarts at zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg      <= ST_RUN;
      presc_cnt_reg  <= 8'h00;
      bit_cnt_reg    <= BIT_START;
      gate_reg       <= '0;
      cpu_resume_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg      <= state_next;
      gate_reg       <= gate_next;
      cpu_resume_reg <= leave_mode & ~i_flag;
      if (state_reg != ST_STOP) begin
        presc_cnt_reg <= presc_cnt_reg + 8'h01;
      end
      if ((state_reg != ST_STAB) && (state_next == ST_STAB)) begin
        bit_cnt_reg <= BIT_START;
      end else if ((state_reg != ST_STOP) && tick) begin
        bit_cnt_reg <= bit_cnt_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  a_sleep_code_entry: assert property (
    clk_en && state_reg == ST_RUN && ssc_reg == SSC_SLEEP |=> state_reg == ST_SLEEP)
    else $error("sleep code did not enter sleep");

  a_stop_needs_code: assert property (
    state_reg == ST_RUN && ssc_reg != SSC_STOP |=> state_reg != ST_STOP)
    else $error("stop entered without stop code");

  a_stray_code_idle: assert property (
    state_reg == ST_RUN && ssc_reg != SSC_STOP && ssc_reg != SSC_SLEEP
    |=> state_reg == ST_RUN)
    else $error("undefined code entered a mode");

  a_stop_clock_gating: assert property (
    state_reg == ST_STOP |-> !gate_reg.osc_run && !gate_reg.sys_clk_run
      && !gate_reg.periph_clk_run && gate_reg.cpu_halt && !gate_reg.bit_run)
    else $error("clocks running in stop");

  a_sleep_keeps_osc: assert property (
    state_reg == ST_SLEEP |-> gate_reg.osc_run && gate_reg.cpu_halt
      && gate_reg.tmr_run && !gate_reg.buz_adc_run)
    else $error("sleep gating wrong");

  a_stab_from_zero: assert property (
    state_reg != ST_STAB ##1 state_reg == ST_STAB |-> bit_cnt_reg == BIT_START)
    else $error("stabilisation count not from zero");

  a_stab_until_ovf: assert property (
    state_reg == ST_STAB && !(tick && bit_cnt_reg == BIT_END) |=> state_reg == ST_STAB)
    else $error("left stabilisation before overflow");

  a_accept_latency: assert property (
    $rose(|int_accept_reg) |-> $past(|flag_reg, 12))
    else $error("accepted in under twelve cycles");

  a_accept_clears: assert property (
    |int_accept_reg |-> i_flag_clr_reg && $onehot(int_accept_reg)
      && ((pend_q_reg & int_accept_reg) == 4'h0))
    else $error("acceptance did not clear flags");

  a_resume_flag_low: assert property (
    cpu_resume_reg |-> !$past(i_flag) && $past(state_reg) == ST_STAB)
    else $error("resume with master flag set");

  a_port_select_gate: assert property (
    (flag_reg & ~$past(flag_reg) & ~$past(port_sel_reg)) == 4'h0)
    else $error("flag set on unselected pin");

  a_edge_sets_flag: assert property (
    clk_en && |set_vec |=> (flag_reg & $past(set_vec)) == $past(set_vec))
    else $error("edge lost its flag");

  // ----------------------------------------------------------------
  // Wake and hold checks
  // ----------------------------------------------------------------
  a_sleep_wakes_irq: assert property (
    clk_en && state_reg == ST_SLEEP && (periph_irq || (|(flag_reg & irq_en_reg)))
    |=> state_reg == ST_STAB)
    else $error("interrupt did not end sleep");

  a_sleep_needs_irq: assert property (
    state_reg == ST_SLEEP && !periph_irq && !(|(flag_reg & irq_en_reg))
    |=> state_reg == ST_SLEEP)
    else $error("sleep ended with no interrupt");

  a_stop_wake_source: assert property (
    clk_en && state_reg == ST_STOP && ((|stop_wake_src) || (|(flag_reg & irq_en_reg)))
    |=> state_reg == ST_STAB)
    else $error("wake source did not end stop");

  a_stop_no_wake: assert property (
    state_reg == ST_STOP && !(|stop_wake_src) && !(|(flag_reg & irq_en_reg))
    |=> state_reg == ST_STOP)
    else $error("stop ended with no wake source");

  a_resume_flag_clear: assert property (
    clk_en && state_reg == ST_STAB && tick && bit_cnt_reg == BIT_END && !i_flag
    |=> cpu_resume_reg)
    else $error("no resume after wake with flag low");

  a_vector_flag_set: assert property (
    clk_en && i_flag |=> !cpu_resume_reg)
    else $error("resume pulse with master flag set");

  a_stop_unit_gates: assert property (
    $past(clk_en) && state_reg == ST_STOP |-> !gate_reg.presc_run
      && gate_reg.wdt_run == $past(rc_watchdog_mode)
      && gate_reg.tmr_run == $past(evt_count_mode))
    else $error("stop unit gating wrong");

  a_presc_held_stop: assert property (
    state_reg == ST_STOP && $past(state_reg) == ST_STOP |-> $stable(presc_cnt_reg))
    else $error("prescaler moved in stop");

  a_sleep_units_run: assert property (
    state_reg == ST_SLEEP |-> gate_reg.presc_run && gate_reg.bit_run
      && gate_reg.serial_ext_only && !gate_reg.wdt_run)
    else $error("sleep unit gating wrong");

  a_wake_keeps_regs: assert property (
    clk_en && state_reg != ST_RUN && !bus_wr
    |=> $stable(edge_sel_reg) && $stable(port_sel_reg) && $stable(irq_en_reg))
    else $error("control register lost in a mode");

endmodule : psv_ctrl

// file: testbench/psv_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// CPU side: master flag and stop pulse
// ----------------------------------------
module psv_cpu_model (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic set_ie,
  input  wire logic stop_req,
  input  wire logic i_flag_clr_reg,
  output      logic i_flag,
  output      logic stop_exec
);
  // Stop is one instruction, so a pulse never lasts two cycles; the slot after each pulse idles as a no-op
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      i_flag    <= 1'b0;
      stop_exec <= 1'b0;
    end else begin
      stop_exec <= stop_req && !stop_exec;
      if (i_flag_clr_reg)
        i_flag <= 1'b0;
      else if (set_ie)
        i_flag <= 1'b1;
    end
  end
endmodule : psv_cpu_model

// file: testbench/power_save_and_ext_wake_tb.sv
`timescale 1ns/1ps
module power_save_and_ext_wake_tb;
  import psv_pkg::*;
  logic        clk_sys, nrst, cyc, stb, we, ack, periph_irq, set_ie, stop_req;
  logic        i_flag, stop_exec, rc_wd, evt_mode, resume, iclr, ce;
  logic [9:0]  adr;
  logic [3:0]  sel, pins, accept;
  logic [31:0] wdat, rdat;
  logic [4:0]  wake_src;
  logic [7:0]  rd;
  psv_gate_s   gate;
  int          fail_count, compares, cycles;

  psv_ctrl psv_ctrl_inst (.clk_sys(clk_sys), .nrst(nrst), .clk_en(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ext_irq_pin(pins), .stop_exec(stop_exec),
    .i_flag(i_flag), .periph_irq(periph_irq), .stop_wake_src(wake_src),
    .rc_watchdog_mode(rc_wd), .evt_count_mode(evt_mode), .gate_reg(gate),
    .cpu_resume_reg(resume), .int_accept_reg(accept), .i_flag_clr_reg(iclr));
  psv_cpu_model psv_cpu_model_inst (.clk_sys(clk_sys), .nrst(nrst), .set_ie(set_ie),
    .stop_req(stop_req), .i_flag_clr_reg(iclr), .i_flag(i_flag), .stop_exec(stop_exec));

  // ----------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end

  task final_report;
    $display("fail_count %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task cyc_wait(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc_wait

  // Classic cycle; no fixed latency assumed, the timeout ends a hang
  task wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'h0};
    wdat <= {24'h0, d};
    do @(posedge clk_sys); while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task rdchk(input logic [7:0] idx, input logic [7:0] exp, input string msg);
    wb(1'b0, idx, 8'h00);
    check(rd, exp, msg);
  endtask : rdchk

  // Waits out the stabilisation count, which needs over 256 cycles at select 0
  task wait_resume;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (resume !== 1'b1 && n < 700);
    // One entry edge, then 256 ticks up to the overflow with select 0
    check(n, {1'b0, BIT_END} + 9'h002, "stabilisation length");
    check(resume, 1'b1, "no resume pulse");
    @(posedge clk_sys);
    check(gate.cpu_halt, 1'b0, "cpu still halted");
  endtask : wait_resume

  task pulse_stop;
    stop_req <= 1'b1;
    cyc_wait(1);
    stop_req <= 1'b0;
    cyc_wait(3);
  endtask : pulse_stop

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    check(gate.sys_clk_run, 1'b1, "run gates");
    rdchk(IDX_EDGE_SEL, EDGE_SEL_RST, "edge reset");
    rdchk(IDX_PRESC, {5'h0, PRESC_RST}, "presc reset");
    rdchk(IDX_STATUS, 8'h01, "status run");
    rdchk(8'h10, 8'h00, "unmapped read");
    wb(1'b1, IDX_EDGE_SEL, 8'ha5);
    rdchk(IDX_EDGE_SEL, 8'ha5, "edge write");
    // A frozen block must not answer; the write lands once the freeze lifts
    ce <= 1'b0;
    fork
      wb(1'b1, IDX_EDGE_SEL, 8'h5a);
      begin
        cyc_wait(4);
        check(ack, 1'b0, "ack while frozen");
        ce <= 1'b1;
      end
    join
    rdchk(IDX_EDGE_SEL, 8'h5a, "write after freeze");
    nrst <= 1'b0;
    cyc_wait(3);
    nrst <= 1'b1;
    rdchk(IDX_EDGE_SEL, 8'h00, "reset reinit");
  endtask : t_regs

  task t_edges;
    logic [1:0] modes [3];
    modes = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH};
    wb(1'b1, IDX_PORT_SEL, 8'h02);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, IDX_EDGE_SEL, {4'h0, modes[i], 2'h0});
      wb(1'b1, IDX_IRQ_FLAG, 8'h0f);
      pins[1] <= 1'b1;
      cyc_wait(6);
      rdchk(IDX_IRQ_FLAG, {6'h0, modes[i][1], 1'b0}, "rise flag");
      wb(1'b1, IDX_IRQ_FLAG, 8'h0f);
      rdchk(IDX_IRQ_FLAG, 8'h00, "flag set twice");
      pins[1] <= 1'b0;
      cyc_wait(6);
      rdchk(IDX_IRQ_FLAG, {6'h0, modes[i][0], 1'b0}, "fall flag");
    end
    wb(1'b1, IDX_PORT_SEL, 8'h00);
    wb(1'b1, IDX_IRQ_FLAG, 8'h0f);
    pins[1] <= 1'b1;
    cyc_wait(6);
    rdchk(IDX_IRQ_FLAG, 8'h00, "unselected pin");
  endtask : t_edges

  task t_sleep;
    wb(1'b1, IDX_PRESC, 8'h00);
    wb(1'b1, IDX_SSC, SSC_SLEEP);
    cyc_wait(2);
    check(gate.cpu_halt, 1'b1, "sleep halt");
    check(gate.osc_run & gate.tmr_run & gate.presc_run, 1'b1, "sleep runs");
    check(gate.buz_adc_run, 1'b0, "sleep buzzer");
    check(gate.serial_ext_only, 1'b1, "sleep serial");
    rdchk(IDX_STATUS, 8'h02, "sleep held");
    periph_irq <= 1'b1;
    wait_resume();
    periph_irq <= 1'b0;
    rdchk(IDX_SSC, 8'h00, "ssc after wake");
    rdchk(IDX_EDGE_SEL, 8'h0c, "kept on wake");
  endtask : t_sleep

  task t_stop;
    rc_wd <= 1'b1;
    wb(1'b1, IDX_SSC, 8'h33);
    pulse_stop();
    rdchk(IDX_STATUS, 8'h01, "other code");
    wb(1'b1, IDX_SSC, SSC_STOP);
    cyc_wait(3);
    rdchk(IDX_STATUS, 8'h01, "stop w/o instr");
    pulse_stop();
    check(gate.osc_run | gate.sys_clk_run | gate.periph_clk_run, 1'b0, "stop clk");
    check(gate.wdt_run, 1'b1, "rc watchdog");
    check(gate.tmr_run | gate.bit_run, 1'b0, "stop timers");
    check(gate.cpu_halt, 1'b1, "stop halt");
    rdchk(IDX_STATUS, 8'h04, "status stop");
    // Event counting keeps the event counters alive, interval timer stays off; watchdog off without its RC mode
    evt_mode <= 1'b1;
    rc_wd    <= 1'b0;
    cyc_wait(2);
    check({gate.tmr_run, gate.wdt_run}, 2'b10, "stop mode inputs");
    wake_src <= 5'h04;
    wait_resume();
    wake_src <= 5'h00;
  endtask : t_stop

  task t_accept;
    int n;
    wb(1'b1, IDX_EDGE_SEL, {6'h0, EDGE_RISE});
    wb(1'b1, IDX_PORT_SEL, 8'h01);
    wb(1'b1, IDX_IRQ_EN, 8'h01);
    wb(1'b1, IDX_IRQ_FLAG, 8'h0f);
    set_ie <= 1'b1;
    cyc_wait(1);
    set_ie <= 1'b0;
    cyc_wait(1);
    pins[0] <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (accept !== 4'h1 && n < 40);
    // Two sync stages, flag capture, one-cycle look, then the latency count
    check(n, 4 + LAT_CYC, "accept latency");
    check(iclr, 1'b1, "flag clear pulse");
    @(posedge clk_sys);
    #1;
    check({i_flag, accept}, 5'h00, "after accept");
    rdchk(IDX_IRQ_FLAG, 8'h00, "source cleared");
  endtask : t_accept

  initial begin
    {cyc, stb, we, periph_irq, set_ie, stop_req, rc_wd, evt_mode} = '0;
    {adr, pins, wdat, wake_src} = '0;
    sel = 4'hf;
    ce = 1'b1;
    nrst = 1'b0;
    fail_count = 0;
    compares = 0;
    cycles = 0;
    cyc_wait(8);
    nrst <= 1'b1;
    cyc_wait(2);
    t_regs();
    t_edges();
    t_sleep();
    t_stop();
    t_accept();
    final_report();
  end
endmodule : power_save_and_ext_wake_tb
